// [sprx_pkg.sv]
package sprx_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFS_BAUD = 8'h40;
  localparam logic [7:0] OFS_CTRL = 8'h43;
  localparam logic [7:0] OFS_STAT_MAIN = 8'h44;
  localparam logic [7:0] OFS_STAT_AUX = 8'h45;
  localparam logic [7:0] OFS_CTRL2 = 8'h46;
  localparam logic [7:0] OFS_DATA = 8'h47;
  localparam logic [7:0] OFS_INT_STAT = 8'h48;
  localparam logic [7:0] OFS_INT_MASK = 8'h49;
  localparam logic [7:0] OFS_DATA_HI = 8'h4A;

  // Reset values
  localparam logic [7:0] BAUD_RST = 8'h04;
  localparam logic [7:0] AUX_RST = 8'h00;

  // Control register fields
  localparam int CTRL_NINE_BIT = 4;
  localparam int CTRL_PAR_EN = 1;
  localparam int CTRL_PAR_ODD = 0;
  localparam int CTRL2_RX_EN = 2;
  localparam int CTRL2_STANDBY = 1;

  // Auxiliary status fields
  localparam int AUX_BRK_FLAG = 7;
  localparam int AUX_EDGE_FLAG = 6;
  localparam int AUX_UNUSED = 5;
  localparam int AUX_RX_INV = 4;
  localparam int AUX_IDLE_WAKE = 3;
  localparam int AUX_LONG_BRK = 2;
  localparam int AUX_BRK_EN = 1;
  localparam int AUX_RX_ACTIVE = 0;

  // Interrupt status / mask fields
  localparam int INT_W = 5;
  localparam int INT_FULL = 0;
  localparam int INT_ERR = 1;
  localparam int INT_BRK = 2;
  localparam int INT_EDGE = 3;
  localparam int INT_IDLE = 4;

  // Sub-slot indices of the sixteen-times sample clock (RT1 is index 0)
  localparam logic [3:0] RT_START_A = 4'h2;
  localparam logic [3:0] RT_START_B = 4'h4;
  localparam logic [3:0] RT_START_C = 4'h6;
  localparam logic [3:0] RT_VOTE_A = 4'h7;
  localparam logic [3:0] RT_VOTE_B = 4'h8;
  localparam logic [3:0] RT_DECIDE = 4'h9;
  localparam logic [3:0] RT_LAST = 4'hF;
  localparam logic [3:0] RT_AFTER_EDGE = 4'h1;
  localparam logic [1:0] ONES_NEEDED = 2'h3;

  // Data bit counts and idle character length in sample ticks
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;

  // Transmitted break lengths in bit times
  localparam logic [3:0] BRK_SHORT = 4'hA;
  localparam logic [3:0] BRK_SHORT_9 = 4'hB;
  localparam logic [3:0] BRK_LONG = 4'hD;
  localparam logic [3:0] BRK_LONG_9 = 4'hE;

  // Main status flags, laid out as the main status register bits [5:0]
  typedef struct packed {
    logic full;
    logic idle;
    logic overrun;
    logic noise;
    logic frame;
    logic parity;
  } sprx_flags_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP,
    ST_BRKX,
    ST_WAITHI
  } sprx_state_t;

endpackage : sprx_pkg

// [sprx_receiver.sv]
// Function
// R1: Framing error flag sets with receive-full when stop bit samples zero.
// R2: Framing error clears by status read with flag set, then data read.
// R3: Parity error sets with receive-full when enabled parity bit mismatches.
// R4: Parity error clears by status read followed by data read.
// R5: Break flag sets on break character when enabled; write one clears.
// R6: Edge flag sets on active receive edge; write one clears it.
// R7: Receive inversion inverts the line for every receiver purpose.
// R8: In standby, idle sets idle flag only when idle-wake-detect is one.
// R9: Break length 10/11 bits normally, 13/14 bits with long-break select.
// R10: Long-break select never changes framing error detection.
// R11: Break detect enable lengthens detection, blocks framing and full flags.
// R12: Completed character moves to empty data register, sets receive-full.
// R13: Character completing while full sets overrun and is discarded.
// R14: Software reads data within one character time to avoid overrun.
// R15: Receive-full clears by status access then data read, no write.
// R16: No transfer into data register while framing error stays set.
// R17: Standby inhibits receiver flags except idle with idle-wake-detect; the code still sets the edge flag in standby.
// R18: Each bit is majority of sixteen-times samples at slots 8, 9, 10; the code votes the start bit at slots 3, 5, 7.
// R19: Auxiliary status bit five reads zero; writes to it ignored.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module sprx_receiver (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_rx,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic [3:0] o_tx_break_bits
);

  // Two-out-of-three vote
  function automatic logic sprx_maj(input logic a, input logic b, input logic c);
    sprx_maj = (a & b) | (a & c) | (b & c);
  endfunction : sprx_maj

  // Register address match, shared by read and write decode
  function automatic logic sprx_hit(input logic [7:0] a, input logic [7:0] ofs);
    sprx_hit = (a == ofs);
  endfunction : sprx_hit

  // Break length in bit times for the transmitter side
  function automatic logic [3:0] sprx_brk_len(input logic long_sel, input logic nine);
    if (long_sel) begin
      sprx_brk_len = nine ? sprx_pkg::BRK_LONG_9 : sprx_pkg::BRK_LONG;
    end else begin
      sprx_brk_len = nine ? sprx_pkg::BRK_SHORT_9 : sprx_pkg::BRK_SHORT;
    end
  endfunction : sprx_brk_len

  // Software-visible state
  logic [7:0] baud_q;
  logic [7:0] ctrl_q;
  logic [7:0] aux_q;
  logic rx_en_q;
  logic standby_q;
  logic [8:0] data_q;
  logic [sprx_pkg::INT_W-1:0] int_stat_q;
  logic [sprx_pkg::INT_W-1:0] int_mask_q;
  sprx_pkg::sprx_flags_t flag_q;
  sprx_pkg::sprx_flags_t arm_q;
  logic [7:0] rdata_q;

  // Receiver state
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;
  logic [7:0] div_q;
  sprx_pkg::sprx_state_t st_q;
  sprx_pkg::sprx_state_t st_d;
  logic [3:0] rt_q;
  logic [3:0] rt_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [1:0] vote_q;
  logic [1:0] vote_d;
  logic [8:0] shift_q;
  logic [8:0] shift_d;
  logic noise_q;
  logic noise_d;
  logic [1:0] ones_q;
  logic [1:0] ones_d;
  logic [7:0] idle_cnt_q;
  logic idle_arm_q;

  // Control field views
  wire nine_bit = ctrl_q[sprx_pkg::CTRL_NINE_BIT];
  wire par_en = ctrl_q[sprx_pkg::CTRL_PAR_EN];
  wire par_odd = ctrl_q[sprx_pkg::CTRL_PAR_ODD];
  wire rx_inv = aux_q[sprx_pkg::AUX_RX_INV];
  wire idle_wake = aux_q[sprx_pkg::AUX_IDLE_WAKE];
  wire long_brk = aux_q[sprx_pkg::AUX_LONG_BRK];
  wire brk_en = aux_q[sprx_pkg::AUX_BRK_EN];

  // Bus decode
  wire wr_baud = i_wr & sprx_hit(i_addr, sprx_pkg::OFS_BAUD);
  wire wr_ctrl = i_wr & sprx_hit(i_addr, sprx_pkg::OFS_CTRL);
  wire wr_aux = i_wr & sprx_hit(i_addr, sprx_pkg::OFS_STAT_AUX);
  wire wr_ctrl2 = i_wr & sprx_hit(i_addr, sprx_pkg::OFS_CTRL2);
  wire wr_int_stat = i_wr & sprx_hit(i_addr, sprx_pkg::OFS_INT_STAT);
  wire wr_int_mask = i_wr & sprx_hit(i_addr, sprx_pkg::OFS_INT_MASK);
  wire rd_status = i_rd & sprx_hit(i_addr, sprx_pkg::OFS_STAT_MAIN);
  wire rd_data = i_rd & sprx_hit(i_addr, sprx_pkg::OFS_DATA);

  // Line after inversion; only the second synchroniser stage is read
  wire rx_bit = rx_sync_q ^ rx_inv; // R7
  wire edge_ev = rx_prev_q & ~rx_bit; // R6
  wire tick = (div_q >= baud_q); // Lowering the divisor must not stall ticks for a full wrap
  wire rx_active = (st_q != sprx_pkg::ST_IDLE);

  // Vote taken at the deciding sub-slot
  wire bit_val = sprx_maj(vote_q[0], vote_q[1], rx_bit); // R18
  wire bit_noisy = ~((vote_q[0] == vote_q[1]) & (vote_q[1] == rx_bit));
  wire at_decide = tick & (rt_q == sprx_pkg::RT_DECIDE);
  wire [3:0] last_bit = nine_bit ? sprx_pkg::LAST_BIT_9 : sprx_pkg::LAST_BIT_8;
  wire [7:0] idle_ticks = nine_bit ? sprx_pkg::IDLE_TICKS_9 : sprx_pkg::IDLE_TICKS_8;

  // Character completion at mid stop bit
  wire frame_done = (st_q == sprx_pkg::ST_STOP) & at_decide;
  wire [8:0] rx_char = nine_bit ? shift_q : {1'b0, shift_q[8:1]};
  wire char_zero = (rx_char == 9'h000) & ~bit_val;
  wire stop_bad = ~bit_val; // R10
  wire par_bad = par_en & ((^rx_char) != par_odd); // R3
  // Break detect and standby both keep the character out of the data path
  wire deliver = frame_done & ~brk_en & ~standby_q; // R11 R17
  wire xfer = deliver & ~flag_q.full & ~flag_q.frame; // R12 R16
  wire ovr_ev = deliver & flag_q.full; // R13
  wire brk_ev = (st_q == sprx_pkg::ST_BRKX) & at_decide & ~bit_val & brk_en & ~standby_q; // R5

  // Idle line: one full character time of the idle level
  wire idle_full = tick & rx_bit & (st_q == sprx_pkg::ST_IDLE) & (idle_cnt_q == idle_ticks);
  wire idle_ev = idle_full & idle_arm_q & (~standby_q | idle_wake); // R8 R17

  // Flag set and clear vectors
  wire [5:0] flag_set = {xfer, idle_ev, ovr_ev, xfer & noise_d, xfer & stop_bad, xfer & par_bad}; // R1 R3
  wire [5:0] flag_clr = rd_data ? arm_q : 6'h00; // R2 R4 R15
  wire [sprx_pkg::INT_W-1:0] int_ev = {idle_ev, edge_ev, brk_ev, |flag_set[3:0], xfer};

  // Aux register next value: flags W1C with set winning, bit five stays zero
  wire [7:0] aux_wr = {aux_q[7:6] & ~i_wdata[7:6], 1'b0, i_wdata[4:1], 1'b0};
  wire [7:0] aux_base = wr_aux ? aux_wr : aux_q;
  wire [7:0] aux_d = aux_base | {brk_ev, edge_ev, 6'h00}; // R5 R6 R19

  // Read mux
  wire [7:0] aux_view = {aux_q[7:6], 1'b0, aux_q[4:1], rx_active}; // R19
  wire [7:0] rd_mux =
    sprx_hit(i_addr, sprx_pkg::OFS_BAUD) ? baud_q :
    sprx_hit(i_addr, sprx_pkg::OFS_CTRL) ? ctrl_q :
    sprx_hit(i_addr, sprx_pkg::OFS_STAT_MAIN) ? {2'b00, flag_q} :
    sprx_hit(i_addr, sprx_pkg::OFS_STAT_AUX) ? aux_view :
    sprx_hit(i_addr, sprx_pkg::OFS_CTRL2) ? {5'h00, rx_en_q, standby_q, 1'b0} :
    sprx_hit(i_addr, sprx_pkg::OFS_DATA) ? data_q[7:0] :
    sprx_hit(i_addr, sprx_pkg::OFS_DATA_HI) ? {7'h00, data_q[8]} :
    sprx_hit(i_addr, sprx_pkg::OFS_INT_STAT) ? {3'h0, int_stat_q} :
    sprx_hit(i_addr, sprx_pkg::OFS_INT_MASK) ? {3'h0, int_mask_q} :
    8'h00;

  assign o_rdata = rdata_q;
  assign o_irq = |(int_stat_q & int_mask_q);
  assign o_tx_break_bits = sprx_brk_len(long_brk, nine_bit); // R9

  // Receive sequencer: start search, start check, data, stop, long break
  always_comb begin
    st_d = st_q;
    rt_d = tick ? rt_q + 4'h1 : rt_q;
    bit_d = bit_q;
    vote_d = vote_q;
    shift_d = shift_q;
    noise_d = noise_q;
    ones_d = ones_q;
    if (tick & ((rt_q == sprx_pkg::RT_VOTE_A) | (rt_q == sprx_pkg::RT_START_A))) begin
      vote_d[0] = rx_bit;
    end
    if (tick & ((rt_q == sprx_pkg::RT_VOTE_B) | (rt_q == sprx_pkg::RT_START_B))) begin
      vote_d[1] = rx_bit;
    end
    if (at_decide & (st_q != sprx_pkg::ST_START)) begin
      noise_d = noise_q | bit_noisy; // R18
    end
    unique case (st_q)
      sprx_pkg::ST_IDLE: begin
        if (tick) begin
          if (rx_bit) begin
            ones_d = (ones_q == sprx_pkg::ONES_NEEDED) ? ones_q : ones_q + 2'h1;
          end else begin
            ones_d = 2'h0;
            if (ones_q == sprx_pkg::ONES_NEEDED) begin
              st_d = sprx_pkg::ST_START;
              rt_d = sprx_pkg::RT_AFTER_EDGE;
              noise_d = 1'b0;
              shift_d = 9'h000;
            end
          end
        end
      end
      sprx_pkg::ST_START: begin
        if (tick & (rt_q == sprx_pkg::RT_START_C)) begin
          if (sprx_maj(vote_q[0], vote_q[1], rx_bit)) begin
            st_d = sprx_pkg::ST_IDLE;
          end else begin
            noise_d = bit_noisy;
          end
        end else if (tick & (rt_q == sprx_pkg::RT_LAST)) begin
          st_d = sprx_pkg::ST_DATA;
          bit_d = 4'h0;
        end
      end
      sprx_pkg::ST_DATA: begin
        if (at_decide) begin
          shift_d = {bit_val, shift_q[8:1]};
        end
        if (tick & (rt_q == sprx_pkg::RT_LAST)) begin
          if (bit_q == last_bit) begin
            st_d = sprx_pkg::ST_STOP;
          end else begin
            bit_d = bit_q + 4'h1;
          end
        end
      end
      sprx_pkg::ST_STOP: begin
        if (at_decide) begin
          if (char_zero & brk_en) begin
            st_d = sprx_pkg::ST_BRKX; // R11
          end else if (char_zero) begin
            st_d = sprx_pkg::ST_WAITHI;
          end else begin
            // Refill the edge search so a following start is caught at once
            st_d = sprx_pkg::ST_IDLE;
            ones_d = sprx_pkg::ONES_NEEDED;
          end
        end
      end
      sprx_pkg::ST_BRKX: begin
        if (at_decide) begin
          st_d = bit_val ? sprx_pkg::ST_IDLE : sprx_pkg::ST_WAITHI;
          ones_d = 2'h0;
        end
      end
      sprx_pkg::ST_WAITHI: begin
        if (tick & rx_bit) begin
          st_d = sprx_pkg::ST_IDLE;
          ones_d = 2'h1;
        end
      end
    endcase
    // A disabled receiver drops any frame in progress
    if (~rx_en_q) begin
      st_d = sprx_pkg::ST_IDLE;
      ones_d = 2'h0;
    end
  end

  // Line synchroniser and edge history
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b0;
    end else begin
      rx_meta_q <= i_rx;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_bit;
    end
  end

  // Sixteen-times sample clock divider
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= sprx_pkg::ST_IDLE;
      rt_q <= 4'h0;
      bit_q <= 4'h0;
      vote_q <= 2'h0;
      shift_q <= 9'h000;
      noise_q <= 1'b0;
      ones_q <= 2'h0;
    end else begin
      st_q <= st_d;
      rt_q <= rt_d;
      bit_q <= bit_d;
      vote_q <= vote_d;
      shift_q <= shift_d;
      noise_q <= noise_d;
      ones_q <= ones_d;
    end
  end

  // Idle counter; armed by each completed frame so one idle flag per gap
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_cnt_q <= 8'h00;
      idle_arm_q <= 1'b0;
    end else begin
      if (tick) begin
        idle_cnt_q <= (rx_bit & ~rx_active & ~idle_full) ? idle_cnt_q + 8'h01 : 8'h00;
      end
      if (frame_done) begin
        idle_arm_q <= 1'b1;
      end else if (idle_full) begin
        idle_arm_q <= 1'b0;
      end
    end
  end

  // Received character holding register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_q <= 9'h000;
    end else if (xfer) begin
      data_q <= rx_char; // R12
    end
  end

  // Main flags: status read arms, data read clears armed flags, set wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag_q <= '0;
      arm_q <= '0;
    end else begin
      flag_q <= sprx_pkg::sprx_flags_t'(flag_set | (flag_q & ~flag_clr)); // R2 R4 R15
      arm_q <= rd_status ? flag_q : (rd_data ? '0 : arm_q);
    end
  end

  // Control registers; standby wakes on a full idle character
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      baud_q <= sprx_pkg::BAUD_RST;
      ctrl_q <= 8'h00;
      aux_q <= sprx_pkg::AUX_RST;
      rx_en_q <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      baud_q <= wr_baud ? i_wdata : baud_q;
      ctrl_q <= wr_ctrl ? i_wdata : ctrl_q;
      aux_q <= aux_d;
      rx_en_q <= wr_ctrl2 ? i_wdata[sprx_pkg::CTRL2_RX_EN] : rx_en_q;
      if (wr_ctrl2) begin
        standby_q <= i_wdata[sprx_pkg::CTRL2_STANDBY];
      end else if (idle_full) begin
        standby_q <= 1'b0; // R8
      end
    end
  end

  // Interrupt status (W1C, set wins), mask, and registered read data
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_stat_q <= '0;
      int_mask_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      int_stat_q <= int_ev | (int_stat_q & ~(wr_int_stat ? i_wdata[sprx_pkg::INT_W-1:0] : '0));
      int_mask_q <= wr_int_mask ? i_wdata[sprx_pkg::INT_W-1:0] : int_mask_q;
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end

endmodule : sprx_receiver

`default_nettype wire

// [sprx_line_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Remote transmitter on the receive line; frame bits leave LSB first
module sprx_line_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_go,
  input wire logic [15:0] i_bits,
  input wire logic [4:0] i_nbits,
  input wire logic i_inv,
  output logic o_line,
  output logic o_busy
);
  logic [15:0] sh_q;
  logic [4:0] left_q;
  logic [7:0] cnt_q;

  // Idle is the mark level; an inverted link idles low
  assign o_busy = left_q != 5'h00;
  assign o_line = (o_busy ? sh_q[0] : 1'b1) ^ i_inv;

  // One bit per bit time, no gap between frames beyond the caller's
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_q <= 16'h0000;
      left_q <= 5'h00;
      cnt_q <= 8'h00;
    end else if (i_go) begin
      sh_q <= i_bits;
      left_q <= i_nbits;
      cnt_q <= 8'h00;
    end else if (o_busy && cnt_q == 8'(BIT_CLKS - 1)) begin
      cnt_q <= 8'h00;
      sh_q <= sh_q >> 1;
      left_q <= left_q - 5'h01;
    end else if (o_busy) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : sprx_line_model

`default_nettype wire

// [sprx_receiver_asserts.sv]
`timescale 1ns/10ps
`default_nettype none

module sprx_receiver_asserts (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_rx,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic [3:0] o_tx_break_bits
);
  logic main_q;
  logic aux_q;
  logic [5:0] held_q;
  logic [1:0] sticky_q;
  wire data_rd = i_rd && i_addr == sprx_pkg::OFS_DATA;
  wire aux_wr = i_wr && i_addr == sprx_pkg::OFS_STAT_AUX;

  // Flags once seen set must survive until their clearing access
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      main_q <= 1'b0;
      aux_q <= 1'b0;
      held_q <= 6'h00;
      sticky_q <= 2'h0;
    end else begin
      main_q <= i_rd && i_addr == sprx_pkg::OFS_STAT_MAIN;
      aux_q <= i_rd && i_addr == sprx_pkg::OFS_STAT_AUX;
      held_q <= (data_rd || i_wr) ? 6'h00 : (main_q ? held_q | o_rdata[5:0] : held_q);
      sticky_q <= aux_wr ? 2'h0 : (aux_q ? sticky_q | o_rdata[7:6] : sticky_q);
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  chk_rdata_quiet: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_aux_bit5: assert property (aux_q |-> !o_rdata[5])
    else $error("unused aux bit reads one");
  chk_brk_short: assert property (aux_wr && !i_wdata[2] |=> o_tx_break_bits inside {4'hA, 4'hB})
    else $error("short break length wrong");
  chk_brk_long: assert property (aux_wr && i_wdata[2] |=> o_tx_break_bits inside {4'hD, 4'hE})
    else $error("long break length wrong");
  chk_brk_stable: assert property (!i_wr |=> $stable(o_tx_break_bits))
    else $error("break length moved without a write");
  chk_flags_held: assert property (main_q |-> (o_rdata[5:0] & held_q) == held_q)
    else $error("status flag cleared without data read");
  chk_aux_held: assert property (aux_q |-> (o_rdata[7:6] & sticky_q) == sticky_q)
    else $error("aux flag cleared without a write");
  chk_frame_full: assert property (main_q && o_rdata[1] |-> o_rdata[5])
    else $error("frame error without receive full");
endmodule : sprx_receiver_asserts

bind sprx_receiver sprx_receiver_asserts sprx_receiver_asserts_i (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rx(i_rx), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_tx_break_bits(o_tx_break_bits)
);

`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic [3:0] o_tx_break_bits;
  logic go = 1'b0;
  logic [15:0] bits = 16'h0000;
  logic [4:0] nbits = 5'h00;
  logic inv = 1'b0;
  logic busy;
  wire rx_line;
  int num_errors = 0;
  int compares = 0;

  // 100 ns period
  always #50 i_clk = ~i_clk;

  sprx_receiver sprx_receiver_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rx(rx_line), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_tx_break_bits(o_tx_break_bits)
  );

  // Baud divisor is set to 0, so one bit is 16 clocks
  sprx_line_model #(.BIT_CLKS(16)) sprx_line_model_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_go(go), .i_bits(bits),
    .i_nbits(nbits), .i_inv(inv), .o_line(rx_line), .o_busy(busy)
  );

  task automatic stop_test;
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check((o_rdata & m) === e, what);
  endtask : rd

  task automatic send(input logic [15:0] b, input logic [4:0] n);
    int k;
    @(posedge i_clk);
    go <= 1'b1;
    bits <= b;
    nbits <= n;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    for (k = 0; k < 400 && busy; k++) @(posedge i_clk);
    check(busy === 1'b0, "line model stuck");
    repeat (4) @(posedge i_clk);
  endtask : send

  function automatic logic [15:0] frm(input logic [7:0] d, input logic stp);
    return {7'h00, stp, d, 1'b0};
  endfunction : frm

  task automatic check_irq(input logic e);
    @(negedge i_clk);
    check(o_irq === e, "interrupt level");
  endtask : check_irq

  task automatic t_regs;
    logic [3:0] bl [4] = '{sprx_pkg::BRK_SHORT, sprx_pkg::BRK_SHORT_9, sprx_pkg::BRK_LONG, sprx_pkg::BRK_LONG_9};
    rd(sprx_pkg::OFS_STAT_AUX, 8'hFF, sprx_pkg::AUX_RST, "aux reset");
    rd(sprx_pkg::OFS_BAUD, 8'hFF, sprx_pkg::BAUD_RST, "baud reset");
    rd(8'h50, 8'hFF, 8'h00, "unmapped read");
    for (int k = 0; k < 4; k++) begin
      wr(sprx_pkg::OFS_CTRL, k[0] ? 8'h10 : 8'h00);
      wr(sprx_pkg::OFS_STAT_AUX, k[1] ? 8'h24 : 8'h20);
      @(negedge i_clk);
      check(o_tx_break_bits === bl[k], "break length");
    end
    rd(sprx_pkg::OFS_STAT_AUX, 8'h24, 8'h04, "aux bit five");
    wr(sprx_pkg::OFS_CTRL, 8'h00);
    wr(sprx_pkg::OFS_STAT_AUX, 8'h00);
  endtask : t_regs

  task automatic t_rx_irq;
    wr(sprx_pkg::OFS_INT_MASK, 8'h01);
    send(frm(8'h5A, 1'b1), 5'h0A);
    check_irq(1'b1);
    rd(sprx_pkg::OFS_STAT_AUX, 8'h40, 8'h40, "edge flag set");
    wr(sprx_pkg::OFS_STAT_AUX, 8'h40);
    rd(sprx_pkg::OFS_STAT_AUX, 8'h40, 8'h00, "edge flag cleared");
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h20, "full set");
    rd(sprx_pkg::OFS_DATA, 8'hFF, 8'h5A, "data");
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h00, "full cleared");
    wr(sprx_pkg::OFS_INT_MASK, 8'h00);
    check_irq(1'b0);
    wr(sprx_pkg::OFS_INT_MASK, 8'h01);
    check_irq(1'b1);
    wr(sprx_pkg::OFS_INT_STAT, 8'h01);
    check_irq(1'b0);
  endtask : t_rx_irq

  task automatic t_overrun;
    send(frm(8'h11, 1'b1), 5'h0A);
    send(frm(8'h22, 1'b1), 5'h0A);
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h28, "overrun");
    rd(sprx_pkg::OFS_DATA, 8'hFF, 8'h11, "first kept");
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h00, "overrun cleared");
  endtask : t_overrun

  // Long break select on: framing detection must not change
  task automatic t_frame;
    wr(sprx_pkg::OFS_STAT_AUX, 8'h04);
    send(frm(8'h55, 1'b0), 5'h0A);
    // The low stop bit looks like a fresh start edge; drop that false frame
    wr(sprx_pkg::OFS_CTRL2, 8'h00);
    wr(sprx_pkg::OFS_CTRL2, 8'h04);
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h22, "frame error");
    rd(sprx_pkg::OFS_DATA, 8'hFF, 8'h55, "frame data");
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h00, "frame cleared");
    wr(sprx_pkg::OFS_STAT_AUX, 8'h00);
  endtask : t_frame

  // Even parity on bit 7: 0x83 is wrong, 0x03 is right
  task automatic t_parity;
    wr(sprx_pkg::OFS_CTRL, 8'h02);
    send(frm(8'h83, 1'b1), 5'h0A);
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h21, "parity error");
    rd(sprx_pkg::OFS_DATA, 8'hFF, 8'h83, "parity data");
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h00, "parity cleared");
    send(frm(8'h03, 1'b1), 5'h0A);
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h20, "good parity");
    rd(sprx_pkg::OFS_DATA, 8'hFF, 8'h03, "good parity data");
    wr(sprx_pkg::OFS_CTRL, 8'h00);
  endtask : t_parity

  // Receiver off while the line flips, so the flip is no start bit
  task automatic set_inv(input logic v);
    wr(sprx_pkg::OFS_CTRL2, 8'h00);
    @(posedge i_clk);
    inv <= v;
    wr(sprx_pkg::OFS_STAT_AUX, v ? 8'h50 : 8'h40);
    repeat (8) @(posedge i_clk);
    wr(sprx_pkg::OFS_STAT_AUX, v ? 8'h50 : 8'h40);
    wr(sprx_pkg::OFS_CTRL2, 8'h04);
  endtask : set_inv

  task automatic t_invert;
    set_inv(1'b1);
    send(frm(8'hA5, 1'b1), 5'h0A);
    rd(sprx_pkg::OFS_STAT_AUX, 8'h40, 8'h40, "rising edge flag");
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h20, "inverted full");
    rd(sprx_pkg::OFS_DATA, 8'hFF, 8'hA5, "inverted data");
    set_inv(1'b0);
  endtask : t_invert

  task automatic t_break;
    wr(sprx_pkg::OFS_STAT_AUX, 8'h02);
    send(16'h0000, 5'h0D);
    rd(sprx_pkg::OFS_STAT_AUX, 8'h80, 8'h80, "break flag");
    rd(sprx_pkg::OFS_STAT_MAIN, 8'h2F, 8'h00, "no full on break");
    wr(sprx_pkg::OFS_STAT_AUX, 8'h80);
    rd(sprx_pkg::OFS_STAT_AUX, 8'h80, 8'h00, "break cleared");
  endtask : t_break

  // Idle after a frame in standby; the flag depends on idle-wake
  task automatic t_standby;
    for (int w = 0; w < 2; w++) begin
      repeat (200) @(posedge i_clk);
      rd(sprx_pkg::OFS_STAT_MAIN, 8'h20, 8'h00, "nothing pending");
      rd(sprx_pkg::OFS_DATA, 8'h00, 8'h00, "flush");
      wr(sprx_pkg::OFS_STAT_AUX, w[0] ? 8'h08 : 8'h00);
      wr(sprx_pkg::OFS_CTRL2, 8'h06);
      send(frm(8'h33, 1'b1), 5'h0A);
      repeat (200) @(posedge i_clk);
      rd(sprx_pkg::OFS_STAT_MAIN, 8'h30, w[0] ? 8'h10 : 8'h00, "standby idle");
      rd(sprx_pkg::OFS_CTRL2, 8'h02, 8'h00, "standby left");
    end
    wr(sprx_pkg::OFS_STAT_AUX, 8'h00);
  endtask : t_standby

  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_regs();
    wr(sprx_pkg::OFS_BAUD, 8'h00);
    wr(sprx_pkg::OFS_CTRL2, 8'h04);
    t_rx_irq();
    t_overrun();
    t_frame();
    t_parity();
    t_invert();
    t_break();
    t_standby();
    stop_test();
  end

  // Whole run needs well under 10000 clocks
  initial begin
    #3000000;
    num_errors++;
    stop_test();
  end
endmodule : testbench

`default_nettype wire
